/* File: inc/mmfit_pkg.sv */
// Purpose : Shared constants of the module management flag and interrupt block.
// Assumes : Core clock of 100 MHz; 8-bit management registers.
// Notes   : Times are kept in their own units; cycle counts derive from them.

package mmfit_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_KHZ        = 100000;
  localparam int INIT_MAX_MS    = 2000;
  localparam int RST_MIN_US     = 10;
  localparam int INIT_CYC       = INIT_MAX_MS * CLK_KHZ;
  localparam int RST_MIN_CYC    = (RST_MIN_US * CLK_KHZ + 999) / 1000;
  localparam int INIT_CNT_W     = 28;
  localparam int RST_CNT_W      = 11;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADDR_STATUS = 8'h02;
  localparam logic [7:0] ADDR_FLAGS  = 8'h03;
  localparam logic [7:0] ADDR_MASK   = 8'h04;
  localparam logic [7:0] ADDR_CTRL   = 8'h05;
  localparam logic [7:0] ADDR_POWER  = 8'h06;

  // Status fields.
  localparam int ST_NOT_READY_BIT = 0;
  localparam int ST_INIT_BIT      = 1;
  // Flag and mask fields.
  localparam int FLAG_W           = 4;
  localparam int FL_RX_LOS_BIT    = 0;
  localparam int FL_TX_FAULT_BIT  = 1;
  localparam int FL_AUX_BIT       = 2;
  localparam int FL_READY_BIT     = 3;
  // Control fields.
  localparam int CTRL_W           = 4;
  localparam int CT_OVERRIDE_BIT  = 0;
  localparam int CT_POWER_SET_BIT = 1;
  localparam int CT_TRANSMIT_DISABLE_MODE_BIT = 2;
  localparam int CT_LOS_MODE_BIT  = 3;
  // Power status fields.
  localparam int PW_LOW_BIT       = 0;
  localparam int PW_FULL_BIT      = 1;

  localparam logic [FLAG_W-1:0] MASK_RST = 4'h0;
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;

  // ****************************************************************
  // Pin inputs, in synchroniser order
  // ****************************************************************
  localparam int IN_W          = 5;
  localparam int IN_RESET_BIT  = 0;
  localparam int IN_LP_BIT     = 1;
  localparam int IN_LOS_BIT    = 2;
  localparam int IN_FAULT_BIT  = 3;
  localparam int IN_AUX_BIT    = 4;
  localparam logic [IN_W-1:0] IN_RST = 5'h01;

  // ****************************************************************
  // Management states
  // ****************************************************************
  typedef enum logic [2:0] {
    MMFIT_HOLD = 3'h1,
    MMFIT_INIT = 3'h2,
    MMFIT_RUN  = 3'h4
  } mmfit_state_t;

endpackage : mmfit_pkg

/* File: design/mmfit_ctrl.sv */
// Purpose : Management control of a pluggable module: initialization, reset pin,
//           low-power and power override, latched flags with masks, interrupt pin.
// Assumes : Pins are asynchronous to clk; registers reached by a plain strobe port.
// Notes   : Flag, mask and mode reactions take a few cycles; a pin reset needs 1000 low cycles and initialization takes the full 2000 ms.
//
// How it works
// [R1] Initialization ends within 2000 ms after start.
// [R2] Reset pin low 10 us guarantees reset.
// [R3] Interrupt output falls within 200 ms.
// [R4] Cleared flags release interrupt within 500 us.
// [R5] Signal loss sets flag and interrupt quickly.
// [R6] Any flag condition sets flag and interrupt.
// [R7] Setting mask stops interrupt within 100 ms.
// [R8] Clearing mask resumes interrupt within 100 ms.
// [R9] Transmit fault sets flag and interrupt.
// [R10] Fully functional within 2 s of power.
// [R11] Register port answers within 2 s.
// [R12] Data-not-ready clears, interrupt asserts after init.
// [R13] Fully functional within 2 s after reset.
// [R14] Dual input mode switch within 100 ms.
// [R15] Low-power pin high gives class 1 power.
// [R16] Low-power pin low gives full function.
// [R17] Dual output mode switch within 100 ms.
// [R18] Override or set bit reduces power.
// [R19] Clearing those bits restores full function.
// [R20] Flags latch until read; interrupt follows them.

`timescale 1ns/1ps

module mmfit_ctrl #(
  parameter int INIT_CYCLES = mmfit_pkg::INIT_CYC
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Host pins
  input  wire logic       reset_n_input,
  input  wire logic       low_power_request,
  output logic            interrupt_n_output,
  output logic            transmit_disable,
  // Receiver and transmitter conditions
  input  wire logic       rx_signal_loss,
  input  wire logic       tx_fault,
  input  wire logic       aux_condition,
  // Power and state indications
  output logic            low_power_state,
  output logic            fully_functional,
  output logic            management_init_state,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic [7:0]      reg_rdata
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // A change counts only once the second and third stages agree, which
  // also rejects single-cycle glitches on the slow host pins.
  logic [mmfit_pkg::IN_W-1:0] sync1_reg;
  logic [mmfit_pkg::IN_W-1:0] sync2_reg;
  logic [mmfit_pkg::IN_W-1:0] sync3_reg;
  logic [mmfit_pkg::IN_W-1:0] filt_reg;
  logic [mmfit_pkg::IN_W-1:0] filt_next;
  logic [mmfit_pkg::IN_W-1:0] pins;

  always_comb begin
    pins      = {aux_condition, tx_fault, rx_signal_loss, low_power_request, reset_n_input};
    filt_next = (sync2_reg & sync3_reg) | (filt_reg & (sync2_reg | sync3_reg));
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_reg <= mmfit_pkg::IN_RST;
      sync2_reg <= mmfit_pkg::IN_RST;
      sync3_reg <= mmfit_pkg::IN_RST;
      filt_reg  <= mmfit_pkg::IN_RST;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg  <= filt_next;
    end
  end

  logic pin_rst_n;
  logic pin_lp;
  logic cond_los;
  logic cond_fault;
  logic cond_aux;

  always_comb begin
    pin_rst_n  = filt_reg[mmfit_pkg::IN_RESET_BIT];
    pin_lp     = filt_reg[mmfit_pkg::IN_LP_BIT];
    cond_los   = filt_reg[mmfit_pkg::IN_LOS_BIT];
    cond_fault = filt_reg[mmfit_pkg::IN_FAULT_BIT];
    cond_aux   = filt_reg[mmfit_pkg::IN_AUX_BIT];
  end

  // ****************************************************************
  // Reset pin and initialization sequence
  // ****************************************************************
  mmfit_pkg::mmfit_state_t            state_reg;
  mmfit_pkg::mmfit_state_t            state_next;
  logic [mmfit_pkg::INIT_CNT_W-1:0]   init_cnt_reg;
  logic [mmfit_pkg::INIT_CNT_W-1:0]   init_cnt_next;
  logic [mmfit_pkg::RST_CNT_W-1:0]    rst_cnt_reg;
  logic [mmfit_pkg::RST_CNT_W-1:0]    rst_cnt_next;
  logic                               rst_long;
  logic                               init_last;
  logic                               init_done_evt;

  localparam logic [mmfit_pkg::RST_CNT_W-1:0] RST_LAST =
    mmfit_pkg::RST_CNT_W'(mmfit_pkg::RST_MIN_CYC - 1);
  localparam logic [mmfit_pkg::INIT_CNT_W-1:0] INIT_LAST =
    mmfit_pkg::INIT_CNT_W'(INIT_CYCLES - 1);

  always_comb begin
    rst_long      = (rst_cnt_reg == RST_LAST) && !pin_rst_n;
    init_last     = (init_cnt_reg == INIT_LAST);
    rst_cnt_next  = rst_cnt_reg;
    init_cnt_next = init_cnt_reg;
    state_next    = state_reg;
    init_done_evt = 1'b0;
    // Shorter low pulses only run the counter and are otherwise ignored.
    if (pin_rst_n) begin
      rst_cnt_next = '0;
    end else if (rst_cnt_reg != RST_LAST) begin
      rst_cnt_next = rst_cnt_reg + 1'b1; // R2
    end
    case (state_reg)
      mmfit_pkg::MMFIT_HOLD: begin
        init_cnt_next = '0;
        if (pin_rst_n) begin
          state_next = mmfit_pkg::MMFIT_INIT; // R13
        end
      end
      mmfit_pkg::MMFIT_INIT: begin
        if (rst_long) begin
          state_next = mmfit_pkg::MMFIT_HOLD; // R2
        end else if (init_last) begin
          state_next    = mmfit_pkg::MMFIT_RUN; // R1
          init_done_evt = 1'b1; // R12
        end else begin
          init_cnt_next = init_cnt_reg + 1'b1; // R1
        end
      end
      mmfit_pkg::MMFIT_RUN: begin
        if (rst_long) begin
          state_next = mmfit_pkg::MMFIT_HOLD; // R2
        end
      end
      default: begin
        state_next = mmfit_pkg::MMFIT_HOLD;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg    <= mmfit_pkg::MMFIT_INIT;
      init_cnt_reg <= '0;
      rst_cnt_reg  <= '0;
    end else begin
      state_reg    <= state_next;
      init_cnt_reg <= init_cnt_next;
      rst_cnt_reg  <= rst_cnt_next;
    end
  end

  logic running;
  logic holding;

  always_comb begin
    running = (state_reg == mmfit_pkg::MMFIT_RUN);
    holding = (state_reg == mmfit_pkg::MMFIT_HOLD);
  end

  // ****************************************************************
  // Registers: flags, masks and control
  // ****************************************************************
  logic [mmfit_pkg::FLAG_W-1:0] flags_reg;
  logic [mmfit_pkg::FLAG_W-1:0] flags_next;
  logic [mmfit_pkg::FLAG_W-1:0] mask_reg;
  logic [mmfit_pkg::FLAG_W-1:0] mask_next;
  logic [mmfit_pkg::CTRL_W-1:0] ctrl_reg;
  logic [mmfit_pkg::CTRL_W-1:0] ctrl_next;
  logic [mmfit_pkg::FLAG_W-1:0] flag_events;
  logic [mmfit_pkg::FLAG_W-1:0] flag_clear;

  function automatic logic hit(input logic strobe, input logic [7:0] a, input logic [7:0] b);
    hit = strobe && (a == b);
  endfunction : hit

  always_comb begin
    flag_events = '0;
    if (running) begin
      flag_events[mmfit_pkg::FL_RX_LOS_BIT]   = cond_los; // R5
      flag_events[mmfit_pkg::FL_TX_FAULT_BIT] = cond_fault; // R9
      flag_events[mmfit_pkg::FL_AUX_BIT]      = cond_aux; // R6
    end
    flag_events[mmfit_pkg::FL_READY_BIT] = init_done_evt; // R12
    // Only the bits the host actually saw are cleared; a new event wins.
    flag_clear = hit(reg_read, reg_addr, mmfit_pkg::ADDR_FLAGS) ? flags_reg : '0;
    flags_next = (flags_reg & ~flag_clear) | flag_events; // R20
    mask_next  = mask_reg;
    ctrl_next  = ctrl_reg;
    if (hit(reg_write, reg_addr, mmfit_pkg::ADDR_MASK)) begin
      mask_next = reg_wdata[mmfit_pkg::FLAG_W-1:0]; // R7 R8
    end
    if (hit(reg_write, reg_addr, mmfit_pkg::ADDR_CTRL)) begin
      ctrl_next = reg_wdata[mmfit_pkg::CTRL_W-1:0]; // R18 R19
    end
    if (holding) begin
      flags_next = '0;
      mask_next  = mmfit_pkg::MASK_RST;
      ctrl_next  = mmfit_pkg::CTRL_RST;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flags_reg <= '0;
      mask_reg  <= mmfit_pkg::MASK_RST;
      ctrl_reg  <= mmfit_pkg::CTRL_RST;
    end else begin
      flags_reg <= flags_next;
      mask_reg  <= mask_next;
      ctrl_reg  <= ctrl_next;
    end
  end

  logic transmit_disable_mode;
  logic los_mode;
  logic low_power_eff;
  logic int_pending;

  always_comb begin
    transmit_disable_mode    = ctrl_reg[mmfit_pkg::CT_TRANSMIT_DISABLE_MODE_BIT];
    los_mode      = ctrl_reg[mmfit_pkg::CT_LOS_MODE_BIT];
    low_power_eff = (!transmit_disable_mode && pin_lp) // R15
                  || ctrl_reg[mmfit_pkg::CT_OVERRIDE_BIT] // R18
                  || ctrl_reg[mmfit_pkg::CT_POWER_SET_BIT];
    int_pending   = |(flags_reg & ~mask_reg); // R20
  end

  // ****************************************************************
  // Registered outputs and read port
  // ****************************************************************
  logic       int_n_reg;
  logic       int_n_next;
  logic       transmit_disable_reg;
  logic       transmit_disable_next;
  logic       lowpwr_reg;
  logic       lowpwr_next;
  logic       full_reg;
  logic       full_next;
  logic       init_st_reg;
  logic       init_st_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  always_comb begin
    // The shared pin shows either the masked interrupt or the raw signal loss.
    int_n_next   = los_mode ? !cond_los : !int_pending; // R3 R4 R7 R8 R17
    transmit_disable_next   = transmit_disable_mode && pin_lp; // R14
    lowpwr_next  = low_power_eff || !running; // R15 R18
    full_next    = running && !low_power_eff; // R10 R13 R16 R19
    init_st_next = !running;
    rdata_next   = 8'h00;
    if (reg_read) begin // R11
      case (reg_addr)
        mmfit_pkg::ADDR_STATUS: begin
          rdata_next[mmfit_pkg::ST_NOT_READY_BIT] = !running; // R12
          rdata_next[mmfit_pkg::ST_INIT_BIT]      = !running;
        end
        mmfit_pkg::ADDR_FLAGS: begin
          rdata_next[mmfit_pkg::FLAG_W-1:0] = flags_reg;
        end
        mmfit_pkg::ADDR_MASK: begin
          rdata_next[mmfit_pkg::FLAG_W-1:0] = mask_reg;
        end
        mmfit_pkg::ADDR_CTRL: begin
          rdata_next[mmfit_pkg::CTRL_W-1:0] = ctrl_reg;
        end
        mmfit_pkg::ADDR_POWER: begin
          rdata_next[mmfit_pkg::PW_LOW_BIT]  = lowpwr_reg;
          rdata_next[mmfit_pkg::PW_FULL_BIT] = full_reg;
        end
        default: begin
          rdata_next = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      int_n_reg   <= 1'b1;
      transmit_disable_reg   <= 1'b0;
      lowpwr_reg  <= 1'b1;
      full_reg    <= 1'b0;
      init_st_reg <= 1'b1;
      rdata_reg   <= 8'h00;
    end else begin
      int_n_reg   <= int_n_next;
      transmit_disable_reg   <= transmit_disable_next;
      lowpwr_reg  <= lowpwr_next;
      full_reg    <= full_next;
      init_st_reg <= init_st_next;
      rdata_reg   <= rdata_next;
    end
  end

  always_comb begin
    interrupt_n_output    = int_n_reg;
    transmit_disable      = transmit_disable_reg;
    low_power_state       = lowpwr_reg;
    fully_functional      = full_reg;
    management_init_state = init_st_reg;
    reg_rdata             = rdata_reg;
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_los_unmasked;
    running && cond_los && !mask_reg[mmfit_pkg::FL_RX_LOS_BIT] && !los_mode;
  endsequence

  // The mask and the output mode must still allow the interrupt when the flag is seen.
  sequence s_los_kept;
    !mask_reg[mmfit_pkg::FL_RX_LOS_BIT] && !los_mode;
  endsequence

  sequence s_los_reported;
    flags_reg[mmfit_pkg::FL_RX_LOS_BIT] ##1 !interrupt_n_output;
  endsequence

  sequence s_init_ending;
    state_reg == mmfit_pkg::MMFIT_INIT && init_last && !rst_long;
  endsequence

  AST_INIT_ENDS: assert property (s_init_ending |=> running ##1 fully_functional || low_power_state) // R1
    else $error("initialization did not end on the last count");
  AST_RESET_PULSE: assert property (!pin_rst_n && rst_cnt_reg == RST_LAST && !holding |=> holding) // R2
    else $error("long reset pulse did not reset the module");
  AST_SHORT_PULSE: assert property (running && pin_rst_n |=> !holding) // R2
    else $error("module reset without a long reset pulse");
  AST_LOS_FLAG: assert property (s_los_unmasked ##1 s_los_kept |-> s_los_reported) // R5
    else $error("signal loss not flagged with interrupt");
  AST_FAULT_FLAG: assert property (running && cond_fault |=> flags_reg[mmfit_pkg::FL_TX_FAULT_BIT]) // R9
    else $error("transmit fault not flagged");
  AST_AUX_FLAG: assert property (running && cond_aux |=> flags_reg[mmfit_pkg::FL_AUX_BIT]) // R6
    else $error("flag condition not latched");
  AST_MASK_INHIBIT: assert property (!los_mode && !int_pending |=> interrupt_n_output) // R7
    else $error("interrupt asserted with every flag masked or clear");
  AST_MASK_RESUME: assert property (!los_mode && int_pending |=> !interrupt_n_output) // R8
    else $error("unmasked flag did not pull interrupt low");
  AST_READ_CLEAR: assert property (hit(reg_read, reg_addr, mmfit_pkg::ADDR_FLAGS) && running // R4
    && !cond_los && !cond_fault && !cond_aux && !init_done_evt |=> flags_reg == '0)
    else $error("read of flags did not clear them");
  AST_READY_FLAG: assert property (s_init_ending |=> flags_reg[mmfit_pkg::FL_READY_BIT]) // R12
    else $error("data ready event not flagged");
  AST_POWER_DOWN: assert property (ctrl_reg[mmfit_pkg::CT_OVERRIDE_BIT] |=> low_power_state) // R18
    else $error("override did not reduce power");
  AST_FULL_POWER: assert property (running && !low_power_eff |=> fully_functional) // R19
    else $error("module not fully functional without low power request");
  AST_TRANSMIT_DISABLE: assert property (transmit_disable_mode && pin_lp |=> transmit_disable) // R14
    else $error("dual input did not act as transmit disable");
  AST_RDATA_ONCE: assert property (!reg_read |=> reg_rdata == 8'h00) // R11
    else $error("read data outside its cycle");

endmodule : mmfit_ctrl

/* File: verif/mmfit_host.sv */
// Purpose : Host management controller model: reset and low-power pins, register port.
// Assumes : Every request changes right after a rising clk edge; register strobes are one cycle long.
// Notes   : Idle address and data show the inverse of the last value, never a stale copy.

`timescale 1ns/1ps

module mmfit_host (
  // Clock
  input  wire logic       clk,
  // Host pins
  output logic            reset_n_input,
  output logic            low_power_request,
  // Register port
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            reg_write,
  output logic            reg_read,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reset_n_input     = 1'b1;
    low_power_request = 1'b0;
    reg_addr          = 8'h00;
    reg_wdata         = 8'h00;
    reg_write         = 1'b0;
    reg_read          = 1'b0;
  end

  // ****************************************************************
  // Register cycles
  // ****************************************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask : rd

  // ****************************************************************
  // Pins
  // ****************************************************************
  // Pulses below the minimum are sent on purpose to show they are ignored.
  task automatic pin_reset(input int cycles);
    @(posedge clk);
    reset_n_input <= 1'b0;
    repeat (cycles) @(posedge clk);
    reset_n_input <= 1'b1;
    #1;
  endtask : pin_reset

  task automatic set_lp(input logic v);
    @(posedge clk);
    low_power_request <= v;
    #1;
  endtask : set_lp
endmodule : mmfit_host

/* File: verif/tb.sv */
// Purpose : Self-checking bench of the management flag and interrupt block.
// Assumes : Initialization shortened to 50 cycles; pin reactions take a few cycles.
// Notes   : Waits are bounded far below the allowed windows, so slow logic is caught.

`timescale 1ns/1ps

module tb;
  localparam int INIT_CYC_TB = 50;
  localparam int LIM         = 20;

  logic       clk;
  logic       resetn;
  logic       rx_signal_loss;
  logic       tx_fault;
  logic       aux_condition;
  logic       reset_n_input;
  logic       low_power_request;
  logic       interrupt_n_output;
  logic       transmit_disable;
  logic       low_power_state;
  logic       fully_functional;
  logic       management_init_state;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_write;
  logic       reg_read;
  logic [7:0] reg_rdata;
  int         num_errors;
  int         n_tests;

  always #5 clk = ~clk;

  mmfit_ctrl #(.INIT_CYCLES(INIT_CYC_TB)) dut (
    .clk(clk), .resetn(resetn), .reset_n_input(reset_n_input),
    .low_power_request(low_power_request), .interrupt_n_output(interrupt_n_output),
    .transmit_disable(transmit_disable), .rx_signal_loss(rx_signal_loss),
    .tx_fault(tx_fault), .aux_condition(aux_condition), .low_power_state(low_power_state),
    .fully_functional(fully_functional), .management_init_state(management_init_state),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata));

  mmfit_host u_host (
    .clk(clk), .reset_n_input(reset_n_input), .low_power_request(low_power_request),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic end_sim();
    if (num_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic out_sel(input int sel);
    case (sel)
      0: return interrupt_n_output;
      1: return management_init_state;
      2: return fully_functional;
      3: return low_power_state;
      default: return transmit_disable;
    endcase
  endfunction : out_sel

  // Select 0 interrupt, 1 init, 2 full function, 3 low power, 4 transmit disable.
  task automatic wait_out(input int sel, input logic v, input int lim);
    int k;
    k = 0;
    while (out_sel(sel) !== v && k < lim) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(8'(out_sel(sel)), 8'(v));
    if (out_sel(sel) !== v) begin
      end_sim();
    end
  endtask : wait_out

  task automatic set_cond(input int i, input logic v);
    @(posedge clk);
    case (i)
      0: rx_signal_loss <= v;
      1: tx_fault <= v;
      default: aux_condition <= v;
    endcase
    #1;
  endtask : set_cond

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_power_up();
    logic [7:0] d;
    chk(8'(management_init_state), 8'h01);
    u_host.rd(mmfit_pkg::ADDR_STATUS, d);
    chk(d, 8'h03);
    wait_out(1, 1'b0, INIT_CYC_TB + LIM);
    wait_out(2, 1'b1, LIM);
    u_host.rd(mmfit_pkg::ADDR_STATUS, d);
    chk(d, 8'h00);
    wait_out(0, 1'b0, LIM);
    u_host.rd(mmfit_pkg::ADDR_FLAGS, d);
    chk(d, 8'h08);
    wait_out(0, 1'b1, LIM);
    u_host.rd(mmfit_pkg::ADDR_POWER, d);
    chk(d, 8'h02);
    u_host.rd(8'h10, d);
    chk(d, 8'h00);
  endtask : t_power_up

  task automatic t_flags();
    logic [7:0] d;
    for (int i = 0; i < 3; i++) begin
      set_cond(i, 1'b1);
      wait_out(0, 1'b0, LIM);
      set_cond(i, 1'b0);
      repeat (10) @(posedge clk);
      u_host.rd(mmfit_pkg::ADDR_FLAGS, d);
      chk(d, 8'(1 << i));
      wait_out(0, 1'b1, LIM);
      u_host.rd(mmfit_pkg::ADDR_FLAGS, d);
      chk(d, 8'h00);
    end
  endtask : t_flags

  // Masking is tried while the flag already pulls the line low.
  task automatic t_mask();
    logic [7:0] d;
    set_cond(0, 1'b1);
    wait_out(0, 1'b0, LIM);
    u_host.wr(mmfit_pkg::ADDR_MASK, 8'h01);
    wait_out(0, 1'b1, LIM);
    u_host.rd(mmfit_pkg::ADDR_MASK, d);
    chk(d, 8'h01);
    u_host.wr(mmfit_pkg::ADDR_MASK, 8'h00);
    wait_out(0, 1'b0, LIM);
    set_cond(0, 1'b0);
    repeat (10) @(posedge clk);
    u_host.rd(mmfit_pkg::ADDR_FLAGS, d);
    chk(d, 8'h01);
    wait_out(0, 1'b1, LIM);
  endtask : t_mask

  task automatic t_modes();
    logic [7:0] d;
    u_host.wr(mmfit_pkg::ADDR_CTRL, 8'h08);
    set_cond(0, 1'b1);
    wait_out(0, 1'b0, LIM);
    set_cond(0, 1'b0);
    wait_out(0, 1'b1, LIM);
    u_host.wr(mmfit_pkg::ADDR_CTRL, 8'h00);
    wait_out(0, 1'b0, LIM);
    u_host.rd(mmfit_pkg::ADDR_FLAGS, d);
    chk(d, 8'h01);
    wait_out(0, 1'b1, LIM);
    u_host.set_lp(1'b1);
    wait_out(3, 1'b1, LIM);
    chk(8'(fully_functional), 8'h00);
    u_host.wr(mmfit_pkg::ADDR_CTRL, 8'h04);
    wait_out(4, 1'b1, LIM);
    wait_out(3, 1'b0, LIM);
    u_host.wr(mmfit_pkg::ADDR_CTRL, 8'h00);
    wait_out(4, 1'b0, LIM);
    wait_out(3, 1'b1, LIM);
    u_host.set_lp(1'b0);
    wait_out(2, 1'b1, LIM);
    for (int j = 0; j < 2; j++) begin
      u_host.wr(mmfit_pkg::ADDR_CTRL, 8'(1 << j));
      wait_out(3, 1'b1, LIM);
      u_host.rd(mmfit_pkg::ADDR_POWER, d);
      chk(d, 8'h01);
      u_host.rd(mmfit_pkg::ADDR_CTRL, d);
      chk(d, 8'(1 << j));
      u_host.wr(mmfit_pkg::ADDR_CTRL, 8'h00);
      wait_out(2, 1'b1, LIM);
    end
  endtask : t_modes

  task automatic t_pin_reset();
    logic [7:0] d;
    u_host.wr(mmfit_pkg::ADDR_MASK, 8'h0F);
    u_host.pin_reset(200);
    repeat (10) @(posedge clk);
    chk(8'(management_init_state), 8'h00);
    u_host.rd(mmfit_pkg::ADDR_MASK, d);
    chk(d, 8'h0F);
    u_host.pin_reset(mmfit_pkg::RST_MIN_CYC + 20);
    chk(8'(management_init_state), 8'h01);
    u_host.rd(mmfit_pkg::ADDR_MASK, d);
    chk(d, 8'h00);
    wait_out(1, 1'b0, INIT_CYC_TB + LIM);
    wait_out(2, 1'b1, LIM);
    u_host.rd(mmfit_pkg::ADDR_FLAGS, d);
    chk(d, 8'h08);
    wait_out(0, 1'b1, LIM);
  endtask : t_pin_reset

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    clk            = 1'b0;
    resetn         = 1'b0;
    rx_signal_loss = 1'b0;
    tx_fault       = 1'b0;
    aux_condition  = 1'b0;
    num_errors     = 0;
    n_tests        = 0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    #1;
    t_power_up();
    t_flags();
    t_mask();
    t_modes();
    t_pin_reset();
    end_sim();
  end
endmodule : tb
